// *** verilog/tbpc_trace_page.sv ***
// trace buffer readout, fill counting and comparator c page compare
`timescale 1ns/1ps
module tbpc_trace_page
  import tbpc_pkg::*;
#(
  parameter int DEPTH_LOG2 = 6
) (
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic        reg_word,
  output logic      [15:0] reg_rdata,
  input  wire logic        store_valid,
  input  wire logic [15:0] store_data,
  input  wire logic [15:0] core_addr,
  input  wire logic [7:0]  program_page_value,
  input  wire logic [15:0] compare_c_value,
  output logic             compare_c_match,
  output logic             armed,
  output logic             break_request,
  output logic             irq
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [15:0]           trace_mem [0:(1<<DEPTH_LOG2)-1];
  logic [DEPTH_LOG2-1:0] rd_ptr_ff;
  logic [DEPTH_LOG2-1:0] wr_ptr_ff;
  logic [5:0]            cnt_ff;
  logic                  full_ff;
  logic                  en_ff;
  logic                  arm_ff;
  logic                  begin_ff;
  logic                  brk_ff;
  logic [7:0]            pagext_ff;
  logic [TBPC_IRQ_WIDTH-1:0] stat_ff;
  logic [TBPC_IRQ_WIDTH-1:0] mask_ff;
  logic [15:0]           rdata_ff;
  logic                  match_ff;
  logic                  brkreq_ff;
  logic                  irq_ff;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  wire        wr_ctrl    = reg_wr && (reg_addr == TBPC_ADDR_CTRL);
  wire        wr_pagext  = reg_wr && (reg_addr == TBPC_ADDR_PAGEXT);
  wire        wr_stat    = reg_wr && (reg_addr == TBPC_ADDR_IRQ_STAT);
  wire        wr_mask    = reg_wr && (reg_addr == TBPC_ADDR_IRQ_MASK);
  // arm only takes effect with enable in the same write
  wire        arm_write  = wr_ctrl && reg_wdata[TBPC_CTRL_ARM_BIT]
                           && reg_wdata[TBPC_CTRL_EN_BIT];
  // misaligned access has reg_addr[0] set; byte access has reg_word low
  wire        data_rd    = reg_rd && (reg_addr[3:1] == TBPC_ADDR_DATA[3:1]);
  wire        data_ok    = data_rd && reg_word && !reg_addr[0]
                           && !arm_ff;
  wire        store_go   = store_valid && arm_ff;
  wire [5:0]  cnt_inc    = cnt_ff + 6'h01;
  wire        wraps      = store_go && (cnt_ff == 6'h3F);
  // once full in begin mode, storage stops; end mode keeps counting
  wire        cnt_run    = store_go && !(full_ff && begin_ff);
  wire        fills      = wraps && !full_ff;
  wire        stop_begin = fills && begin_ff;
  // page bits 7:2 stand for address 21:16, bits 1:0 for address 15:14
  function automatic logic ext_match(
    input logic [7:0] ext,
    input logic [7:0] page
  );
    // upper select bit ignored: no data or extra paging here
    if (!ext[TBPC_PSEL_LO_BIT]) begin
      return 1'b1;
    end
    return ext[5:0] == page[7:2];
  endfunction

  function automatic logic [15:0] low_addr(
    input logic [7:0]  ext,
    input logic [7:0]  page,
    input logic [15:0] addr
  );
    if (!ext[TBPC_PSEL_LO_BIT]) begin
      return addr;
    end
    return {page[1:0], addr[13:0]};
  endfunction

  wire        ext_hit    = ext_match(pagext_ff, program_page_value);
  wire [15:0] hi_addr    = low_addr(pagext_ff, program_page_value, core_addr);
  // comparator works in either breakpoint or debug mode
  wire        cmp_hit    = ext_hit && (hi_addr == compare_c_value);
  wire [TBPC_IRQ_WIDTH-1:0] stat_set = {cmp_hit & ~match_ff, fills};

  // ----------------------------------------
  // register images
  // ----------------------------------------
  // full flag in bit 7, bit 6 reads zero
  wire [15:0] img_count  = {8'h00, full_ff, 1'b0, cnt_ff};
  wire [15:0] img_pagext = {8'h00, pagext_ff};
  wire [15:0] img_ctrl   = {8'h00, en_ff, arm_ff, 1'b0, begin_ff, brk_ff, 3'h0};
  wire [15:0] img_stat   = {{(16-TBPC_IRQ_WIDTH){1'b0}}, stat_ff};
  wire [15:0] img_mask   = {{(16-TBPC_IRQ_WIDTH){1'b0}}, mask_ff};

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  logic [15:0] rd_mux;
  always_comb begin
    rd_mux = 16'h0000;
    case (reg_addr)
      TBPC_ADDR_DATA:     rd_mux = data_ok ? trace_mem[rd_ptr_ff] : 16'h0000;
      TBPC_ADDR_COUNT:    rd_mux = img_count;
      TBPC_ADDR_PAGEXT:   rd_mux = img_pagext;
      TBPC_ADDR_CTRL:     rd_mux = img_ctrl;
      TBPC_ADDR_IRQ_STAT: rd_mux = img_stat;
      TBPC_ADDR_IRQ_MASK: rd_mux = img_mask;
      default:            rd_mux = 16'h0000;
    endcase
  end

  // ----------------------------------------
  // trace memory, no reset on purpose
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (cnt_run) begin
      trace_mem[wr_ptr_ff] <= store_data;
    end
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // one place for the sticky rule: a set in the clear cycle survives
  function automatic logic [TBPC_IRQ_WIDTH-1:0] w1c_next(
    input logic [TBPC_IRQ_WIDTH-1:0] cur,
    input logic                      clr_en,
    input logic [TBPC_IRQ_WIDTH-1:0] clr,
    input logic [TBPC_IRQ_WIDTH-1:0] set
  );
    logic [TBPC_IRQ_WIDTH-1:0] keep;
    keep = clr_en ? (cur & ~clr) : cur;
    return keep | set;
  endfunction

  // pointers wrap at the buffer depth, which makes the ring
  function automatic logic [DEPTH_LOG2-1:0] ptr_next(
    input logic [DEPTH_LOG2-1:0] cur,
    input logic                  step
  );
    return step ? cur + DEPTH_LOG2'(1) : cur;
  endfunction

  // ----------------------------------------
  // next values
  // ----------------------------------------
  logic [DEPTH_LOG2-1:0]     nxt_rd_ptr;
  logic [DEPTH_LOG2-1:0]     nxt_wr_ptr;
  logic [5:0]                nxt_cnt;
  logic                      nxt_full;
  logic                      nxt_en;
  logic                      nxt_arm;
  logic                      nxt_begin;
  logic                      nxt_brk;
  logic [7:0]                nxt_pagext;
  logic [TBPC_IRQ_WIDTH-1:0] nxt_stat;
  logic [TBPC_IRQ_WIDTH-1:0] nxt_mask;
  logic [15:0]               nxt_rdata;
  logic                      nxt_match;
  logic                      nxt_brkreq;
  logic                      nxt_irq;

  // an arm write restarts the session ahead of any store or read
  assign nxt_rd_ptr = arm_write ? '0 : ptr_next(rd_ptr_ff, data_ok);
  assign nxt_wr_ptr = arm_write ? '0 : ptr_next(wr_ptr_ff, cnt_run);
  assign nxt_cnt    = arm_write ? TBPC_CNT_RST :
                      cnt_run   ? cnt_inc      :
                                  cnt_ff;
  assign nxt_full   = arm_write ? 1'b0 : (full_ff | wraps);

  assign nxt_en     = wr_ctrl ? reg_wdata[TBPC_CTRL_EN_BIT] : en_ff;
  // a software write wins over the automatic disarm in the same cycle
  assign nxt_arm    = wr_ctrl    ? arm_write :
                      stop_begin ? 1'b0      :
                                   arm_ff;
  assign nxt_begin  = wr_ctrl ? reg_wdata[TBPC_CTRL_BEGIN_BIT] : begin_ff;
  assign nxt_brk    = wr_ctrl ? reg_wdata[TBPC_CTRL_BRK_BIT] : brk_ff;
  assign nxt_pagext = wr_pagext ? reg_wdata[7:0] : pagext_ff;

  assign nxt_stat   = w1c_next(stat_ff, wr_stat, reg_wdata[TBPC_IRQ_WIDTH-1:0], stat_set);
  assign nxt_mask   = wr_mask ? reg_wdata[TBPC_IRQ_WIDTH-1:0] : mask_ff;
  // read data stands only in the cycle after the strobe
  assign nxt_rdata  = reg_rd ? rd_mux : 16'h0000;
  assign nxt_match  = cmp_hit;
  assign nxt_brkreq = fills && brk_ff;
  assign nxt_irq    = |(stat_ff & mask_ff);

  // ----------------------------------------
  // pointers
  // ----------------------------------------
  // read pointer moves only on an accepted word read or an arm write
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rd_ptr_ff <= '0;
    end else begin
      rd_ptr_ff <= nxt_rd_ptr;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr_ff <= '0;
    end else begin
      wr_ptr_ff <= nxt_wr_ptr;
    end
  end

  // ----------------------------------------
  // count and full flag
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_ff <= TBPC_CNT_RST;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  // full stays up until the next arm write
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      full_ff <= 1'b0;
    end else begin
      full_ff <= nxt_full;
    end
  end

  // ----------------------------------------
  // control
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      en_ff <= TBPC_CTRL_RST[TBPC_CTRL_EN_BIT];
    end else begin
      en_ff <= nxt_en;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      arm_ff <= TBPC_CTRL_RST[TBPC_CTRL_ARM_BIT];
    end else begin
      arm_ff <= nxt_arm;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      begin_ff <= TBPC_CTRL_RST[TBPC_CTRL_BEGIN_BIT];
    end else begin
      begin_ff <= nxt_begin;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      brk_ff <= TBPC_CTRL_RST[TBPC_CTRL_BRK_BIT];
    end else begin
      brk_ff <= nxt_brk;
    end
  end

  // ----------------------------------------
  // page extension
  // ----------------------------------------
  // top extended bits are stored as written; software keeps them zero
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pagext_ff <= TBPC_PAGEXT_RST;
    end else begin
      pagext_ff <= nxt_pagext;
    end
  end

  // ----------------------------------------
  // read data and event outputs
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rdata_ff <= 16'h0000;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      match_ff <= 1'b0;
    end else begin
      match_ff <= nxt_match;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      brkreq_ff <= 1'b0;
    end else begin
      brkreq_ff <= nxt_brkreq;
    end
  end

  // ----------------------------------------
  // interrupts
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      stat_ff <= TBPC_IRQ_RST;
    end else begin
      stat_ff <= nxt_stat;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      mask_ff <= TBPC_IRQ_RST;
    end else begin
      mask_ff <= nxt_mask;
    end
  end

  // one cycle of lag keeps the pin straight off a flop
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= nxt_irq;
    end
  end

  assign reg_rdata       = rdata_ff;
  assign compare_c_match = match_ff;
  assign armed           = arm_ff;
  assign break_request   = brkreq_ff;
  assign irq             = irq_ff;

endmodule

// *** verilog/tbpc_pkg.sv ***
// constants for the trace buffer and page compare block
// Notes on behaviour
// - only aligned word reads return trace data
// - armed word reads return zero, no advance
// - trace data has no fixed reset value
// - full flag set after 64 stored words
// - arm write of one clears full flag
// - six-bit count reports valid words
// - wrap sets full; end mode keeps counting
// - arm write clears whole count register
// - full at zero: begin disarms, break if enabled
// - full with nonzero count means circular overwrite
// - page select: 00 flat, 01 program page
// - upper page select bit ignored
// - program page compares bits 21 to 16
// - comparator usable in breakpoint mode too
// - arm needs debug enable in same write
// - begin bit: start or end at trigger
package tbpc_pkg;
  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [3:0] TBPC_ADDR_DATA     = 4'h0;
  localparam logic [3:0] TBPC_ADDR_COUNT    = 4'h2;
  localparam logic [3:0] TBPC_ADDR_PAGEXT   = 4'h3;
  localparam logic [3:0] TBPC_ADDR_CTRL     = 4'h4;
  localparam logic [3:0] TBPC_ADDR_IRQ_STAT = 4'h5;
  localparam logic [3:0] TBPC_ADDR_IRQ_MASK = 4'h6;
  // ----------------------------------------
  // control fields
  // ----------------------------------------
  localparam int TBPC_CTRL_EN_BIT    = 7;
  localparam int TBPC_CTRL_ARM_BIT   = 6;
  localparam int TBPC_CTRL_BEGIN_BIT = 4;
  localparam int TBPC_CTRL_BRK_BIT   = 3;
  localparam int TBPC_FULL_BIT       = 7;
  localparam int TBPC_PSEL_LO_BIT    = 6;
  // interrupt status bits
  localparam int TBPC_IRQ_FULL_BIT   = 0;
  localparam int TBPC_IRQ_MATCH_BIT  = 1;
  localparam int TBPC_IRQ_WIDTH      = 2;
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [7:0] TBPC_CTRL_RST   = 8'h00;
  localparam logic [7:0] TBPC_PAGEXT_RST = 8'h00;
  localparam logic [5:0] TBPC_CNT_RST    = 6'h00;
  localparam logic [1:0] TBPC_IRQ_RST    = 2'h0;
endpackage

// *** dv/tbpc_trace_page_monitor.sv ***
// port-level assertions for the trace page block
`timescale 1ns/1ps
module tbpc_trace_page_monitor
  import tbpc_pkg::*;
#(
  parameter int DEPTH_LOG2 = 6
) (
  input wire logic        core_clk,
  input wire logic        resetn,
  input wire logic [3:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic        reg_word,
  input wire logic [15:0] reg_rdata,
  input wire logic        store_valid,
  input wire logic        armed,
  input wire logic        break_request
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!resetn);
  wire logic data_rd = reg_rd && reg_addr == TBPC_ADDR_DATA;
  wire logic ctl_wr  = reg_wr && reg_addr == TBPC_ADDR_CTRL;
  sequence s_arm;
    ctl_wr && reg_wdata[7:6] == 2'b11 && !store_valid;
  endsequence
  sequence s_cnt_rd;
    reg_rd && reg_addr == TBPC_ADDR_COUNT && !store_valid;
  endsequence
  property p_byte; data_rd && !reg_word |=> reg_rdata == 16'h0000; endproperty
  a_byte: assert property (p_byte) else $error("byte read of trace data not zero");
  property p_misal; reg_rd && reg_addr == 4'h1 |=> reg_rdata == 16'h0000; endproperty
  a_misal: assert property (p_misal) else $error("misaligned trace read not zero");
  property p_armrd; data_rd && armed |=> reg_rdata == 16'h0000; endproperty
  a_armrd: assert property (p_armrd) else $error("armed trace read not zero");
  property p_cntfmt; reg_rd && reg_addr == TBPC_ADDR_COUNT |=> reg_rdata[15:8] == 8'h00 && !reg_rdata[6]; endproperty
  a_cntfmt: assert property (p_cntfmt) else $error("count register layout wrong");
  property p_clr; s_arm ##1 !store_valid ##1 s_cnt_rd |=> reg_rdata == 16'h0000; endproperty
  a_clr: assert property (p_clr) else $error("count not cleared by arm");
  property p_arm01; ctl_wr && reg_wdata[7:6] == 2'b01 && !armed |=> !armed; endproperty
  a_arm01: assert property (p_arm01) else $error("armed without enable");
  property p_arm11; s_arm |=> armed; endproperty
  a_arm11: assert property (p_arm11) else $error("arm write ignored");
  property p_brk; break_request |=> !break_request; endproperty
  a_brk: assert property (p_brk) else $error("break request longer than one cycle");
endmodule

// *** dv/tbpc_core_model.sv ***
// core side model: trace store stream
`timescale 1ns/1ps
module tbpc_core_model (
  input  wire logic        core_clk,
  input  wire logic        go,
  input  wire logic [15:0] word,
  output logic             store_valid,
  output logic      [15:0] store_data
);
  logic [15:0] last_ff;
  always_ff @(posedge core_clk) if (go) last_ff <= word;
  assign store_valid = go;
  // idle data inverts the last word so stale values never pass
  assign store_data  = go ? word : ~last_ff;
endmodule

// *** dv/trace_buffer_and_page_compare_tb.sv ***
// self-checking bench for the trace page block
`timescale 1ns/1ps
module trace_buffer_and_page_compare_tb;
  import tbpc_pkg::*;
  logic        core_clk = 0, resetn = 0, reg_wr = 0, reg_rd = 0, reg_word = 0, go = 0;
  logic [3:0]  reg_addr = 0;
  logic [7:0]  program_page_value = 0;
  logic [15:0] reg_wdata = 0, word = 0, core_addr = 0, compare_c_value = 0, reg_rdata, store_data, mem [64];
  logic        store_valid, compare_c_match, armed, break_request, irq;
  int          mismatches = 0, comparisons = 0, cycles = 0, brk_cnt = 0;
  integer      seed = 32'heb85282e;
  tbpc_trace_page i_tbpc_trace_page (.*);
  tbpc_core_model i_tbpc_core_model (.*);
  always #2.5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles++;
    if (break_request) brk_cnt++;
    if (cycles == 4000) begin
      mismatches++;
      finish_test();
    end
  end
  task automatic check(input logic [15:0] s, input logic [15:0] e);
    comparisons++;
    if (s !== e) begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= {8'h00, d};
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rdc(input logic [3:0] a, input logic w, input logic [15:0] e);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    reg_word <= w;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 check(reg_rdata, e);
  endtask
  task automatic burst(input int n);
    integer w;
    for (int k = 0; k < n; k++) begin
      w = $random(seed);
      @(posedge core_clk);
      go <= 1'b1;
      word <= w[15:0];
      mem[k % 64] = w[15:0];
    end
    @(posedge core_clk);
    go <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
  endtask
  function automatic logic exp_match(input logic [7:0] px, input logic [15:0] cv, a, input logic [7:0] p);
    if (!px[6]) return cv == a;
    return px[5:0] == p[7:2] && cv == {p[1:0], a[13:0]};
  endfunction
  task automatic finish_test();
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    logic [7:0]  px, pg;
    logic [15:0] a, cv;
    repeat (5) @(posedge core_clk);
    resetn <= 1'b1;
    rdc(TBPC_ADDR_COUNT, 1'b1, 16'h0000);
    rdc(TBPC_ADDR_PAGEXT, 1'b1, 16'h0000);
    wr(TBPC_ADDR_CTRL, 8'h40);
    check({15'h0000, armed}, 16'h0000);
    wr(TBPC_ADDR_CTRL, 8'hC0);
    burst(64);
    rdc(TBPC_ADDR_COUNT, 1'b1, 16'h0080);
    wr(TBPC_ADDR_CTRL, 8'h80);
    rdc(TBPC_ADDR_DATA, 1'b0, 16'h0000);
    rdc(4'h1, 1'b1, 16'h0000);
    rdc(TBPC_ADDR_DATA, 1'b1, mem[0]);
    rdc(TBPC_ADDR_DATA, 1'b1, mem[1]);
    wr(TBPC_ADDR_CTRL, 8'hC0);
    rdc(TBPC_ADDR_COUNT, 1'b1, 16'h0000);
    rdc(TBPC_ADDR_DATA, 1'b1, 16'h0000);
    burst(65);
    rdc(TBPC_ADDR_COUNT, 1'b1, 16'h0081);
    wr(TBPC_ADDR_CTRL, 8'h80);
    rdc(TBPC_ADDR_DATA, 1'b1, mem[0]);
    // begin mode with break: full disarms and later stores are refused
    wr(TBPC_ADDR_IRQ_MASK, 8'h01);
    wr(TBPC_ADDR_CTRL, 8'hD8);
    burst(66);
    rdc(TBPC_ADDR_COUNT, 1'b1, 16'h0080);
    check({15'h0000, armed}, 16'h0000);
    check(16'(brk_cnt), 16'h0001);
    check({15'h0000, irq}, 16'h0001);
    wr(TBPC_ADDR_IRQ_MASK, 8'h00);
    burst(0);
    check({15'h0000, irq}, 16'h0000);
    wr(TBPC_ADDR_IRQ_STAT, 8'h03);
    wr(TBPC_ADDR_IRQ_MASK, 8'h01);
    burst(0);
    check({15'h0000, irq}, 16'h0000);
    for (int i = 0; i < 16; i++) begin
      px = {i[1:0], 2'b00, 4'($random(seed))};
      a = 16'($random(seed));
      pg = {px[5:0] ^ {5'h00, i[2]}, 2'($random(seed))};
      cv = (px[6] ? {pg[1:0], a[13:0]} : a) ^ {15'h0000, i[3]};
      wr(TBPC_ADDR_PAGEXT, px);
      @(posedge core_clk);
      core_addr <= a;
      program_page_value <= pg;
      compare_c_value <= cv;
      burst(0);
      check({15'h0000, compare_c_match}, {15'h0000, exp_match(px, cv, a, pg)});
    end
    finish_test();
  end
endmodule
bind tbpc_trace_page tbpc_trace_page_monitor #(.DEPTH_LOG2(DEPTH_LOG2)) i_tbpc_trace_page_monitor (.*);
